// file: design/rsf_pkg.sv
`default_nettype none
package rsf_pkg;

  localparam logic [3:0] ADDR_SRC = 4'h0;
  localparam logic [3:0] ADDR_BFC = 4'h4;
  localparam logic [3:0] ADDR_IST = 4'h8;
  localparam logic [3:0] ADDR_IMK = 4'hC;

  localparam int BIT_POR = 7;
  localparam int BIT_PIN = 6;
  localparam int BIT_WDOG = 5;
  localparam int BIT_BADOP = 4;
  localparam int BIT_BADADR = 3;
  localparam int BIT_MON = 2;
  localparam int BIT_LVI = 1;
  localparam int BIT_BREAK_CLEAR_ENABLE = 7;

  localparam logic [7:0] SRC_RESET = 8'h80;
  localparam logic [7:0] BFC_RESET = 8'h00;
  localparam logic [7:0] IST_RESET = 8'h00;
  localparam logic [7:0] IMK_RESET = 8'h00;
  localparam logic [7:0] SRC_MASK = 8'hFE;

  // non-power-on reset causes, in register order (pin first)
  typedef struct packed {
    logic pin;
    logic wdog;
    logic bad_op;
    logic bad_addr;
    logic monitor;
    logic low_voltage_reset_flag;
  } rsf_src_t;

  typedef struct packed {
    logic [3:0] adr;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
  } rsf_wb_req_t;

endpackage : rsf_pkg
`default_nettype wire

// file: design/rsf_reset_flags.sv
// How it works
// - flags register records which source caused the latest reset.
// - a read of the flags register clears all flags after data returns.
// - power-on sets its own flag and clears all the others.
// - other sources set only their own flag; flags accumulate until read.
// - several flags may be set together, e.g. power-on and low voltage.
// - external reset pin sets the pin flag; zero after power-on or read.
// - watchdog reset sets the watchdog flag; zero after power-on or read.
// - illegal opcode reset sets its flag; zero after power-on or read.
// - fetch from unimplemented address sets its flag; zero after power-on or read.
// - monitor entry on erased reset vector sets the monitor flag.
// - low-voltage inhibit reset sets its flag; zero after power-on or read.
// - break clear enable is software read/write; set allows break-time clears.
// - enable 1 lets status clear in break, 0 protects status.
// - break clear enable resets to zero, protecting status by default.
// - a bit cleared during break stays cleared after break ends.
// - with enable 0, a half-done two-step clear holds during break.
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module rsf_reset_flags (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire rsf_pkg::rsf_src_t reset_cause_i,
  input wire logic break_active_i,
  output logic status_clear_allow_o,
  output logic irq_o
);

  typedef struct packed {
    rsf_pkg::rsf_src_t src_s1;
    rsf_pkg::rsf_src_t src_s2;
    rsf_pkg::rsf_src_t src_prev;
    logic brk_s1;
    logic brk_s2;
    logic [7:0] flags;
    logic [7:0] bfc;
    logic [7:0] ist;
    logic [7:0] imk;
    logic ack;
    logic [31:0] dat;
    logic clr_allow;
    logic irq;
  } rsf_state_t;

  rsf_state_t state_reg;
  rsf_state_t state_next;

  // maps the cause struct onto register bit positions
  function automatic logic [7:0] src_to_bits(input rsf_pkg::rsf_src_t s);
    logic [7:0] b;
    b = 8'h00;
    b[rsf_pkg::BIT_PIN] = s.pin;
    b[rsf_pkg::BIT_WDOG] = s.wdog;
    b[rsf_pkg::BIT_BADOP] = s.bad_op;
    b[rsf_pkg::BIT_BADADR] = s.bad_addr;
    b[rsf_pkg::BIT_MON] = s.monitor;
    b[rsf_pkg::BIT_LVI] = s.low_voltage_reset_flag;
    return b;
  endfunction : src_to_bits

  function automatic logic [31:0] zext8(input logic [7:0] v);
    return {24'h000000, v};
  endfunction : zext8

  logic req;
  logic wr;
  logic rd;
  logic lane0;
  logic allow;
  logic [7:0] evt;
  logic [7:0] rd_byte;

  always_comb begin
    state_next = state_reg;
    req = wb_cyc_i && wb_stb_i && !state_reg.ack;
    wr = req && wb_we_i;
    rd = req && !wb_we_i;
    lane0 = wb_sel_i[0];
    // break gating: clears pass unless in break with enable low
    allow = !state_reg.brk_s2 || state_reg.bfc[rsf_pkg::BIT_BREAK_CLEAR_ENABLE];

    // cross cause and break levels in from the reset/debug logic
    state_next.src_s1 = reset_cause_i;
    state_next.src_s2 = state_reg.src_s1;
    state_next.src_prev = state_reg.src_s2;
    state_next.brk_s1 = break_active_i;
    state_next.brk_s2 = state_reg.brk_s1;

    // a cause counts once, on its rising edge, so a held level does not re-set
    evt = src_to_bits(state_reg.src_s2) & ~src_to_bits(state_reg.src_prev);

    rd_byte = 8'h00;
    case (wb_adr_i)
      rsf_pkg::ADDR_SRC: rd_byte = state_reg.flags;
      rsf_pkg::ADDR_BFC: rd_byte = state_reg.bfc;
      rsf_pkg::ADDR_IST: rd_byte = state_reg.ist;
      rsf_pkg::ADDR_IMK: rd_byte = state_reg.imk;
      default: rd_byte = 8'h00;
    endcase

    state_next.ack = req;
    if (rd) begin
      state_next.dat = zext8(rd_byte);
    end else begin
      state_next.dat = 32'h00000000;
    end

    // read data is latched with the old flags; clear applies behind it
    // a new cause landing in the same cycle as the clear still wins
    if (rd && wb_adr_i == rsf_pkg::ADDR_SRC && allow) begin
      state_next.flags = evt;
    end else begin
      state_next.flags = state_reg.flags | evt;
    end
    // pin, watchdog, opcode, address, monitor and lvi all enter through evt

    if (wr && lane0) begin
      case (wb_adr_i)
        rsf_pkg::ADDR_BFC: begin
          state_next.bfc = wb_dat_i[7:0] & 8'h80;
        end
        rsf_pkg::ADDR_IMK: begin
          state_next.imk = wb_dat_i[7:0] & rsf_pkg::SRC_MASK;
        end
        default: begin
          state_next.bfc = state_reg.bfc;
        end
      endcase
    end

    // sticky event bits, write one to clear, also guarded during break
    if (wr && lane0 && wb_adr_i == rsf_pkg::ADDR_IST && allow) begin
      state_next.ist = (state_reg.ist & ~wb_dat_i[7:0]) | evt;
    end else begin
      state_next.ist = state_reg.ist | evt;
    end

    state_next.clr_allow = allow;
    state_next.irq = |(state_next.ist & state_next.imk);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg.src_s1 <= '0;
      state_reg.src_s2 <= '0;
      state_reg.src_prev <= '0;
      state_reg.brk_s1 <= 1'b0;
      state_reg.brk_s2 <= 1'b0;
      // this reset is the power-on reset of the always-on domain
      state_reg.flags <= rsf_pkg::SRC_RESET;
      state_reg.bfc <= rsf_pkg::BFC_RESET;
      state_reg.ist <= rsf_pkg::IST_RESET;
      state_reg.imk <= rsf_pkg::IMK_RESET;
      state_reg.ack <= 1'b0;
      state_reg.dat <= 32'h00000000;
      state_reg.clr_allow <= 1'b1;
      state_reg.irq <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.dat;
  assign status_clear_allow_o = state_reg.clr_allow;
  assign irq_o = state_reg.irq;

endmodule : rsf_reset_flags

`default_nettype wire

// file: verification/rsf_reset_flags_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rsf_reset_flags_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic break_active_i,
  input wire logic status_clear_allow_o,
  input wire logic irq_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("stray ack");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
  AST_DAT_UNMAPPED: assert property (wb_ack_o && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0)
    else $error("unmapped data");
  AST_READ_HIGH: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper data");
  AST_RESET_VAL: assert property ($rose(rst_n) |-> !irq_o && status_clear_allow_o)
    else $error("reset value");
  AST_ALLOW_IDLE: assert property (!break_active_i [*4] |-> status_clear_allow_o)
    else $error("allow low");
  AST_ALLOW_FALL: assert property ($fell(status_clear_allow_o) |-> $past(break_active_i, 3))
    else $error("allow fell");
endmodule : rsf_reset_flags_chk
bind rsf_reset_flags rsf_reset_flags_chk u_chk (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .break_active_i(break_active_i),
  .status_clear_allow_o(status_clear_allow_o), .irq_o(irq_o));
`default_nettype wire

// file: verification/rsf_reset_flags_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rsf_reset_flags_bench;
  logic clk, rst_n, cyc, stb, we, brk, irq, allow, ack;
  logic [3:0] adr, sel;
  logic [31:0] dat, dat_o, q;
  rsf_pkg::rsf_src_t cause;
  int num_errors, check_count, cycles;
  rsf_reset_flags DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .reset_cause_i(cause), .break_active_i(brk), .status_clear_allow_o(allow), .irq_o(irq));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task summarize;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // hang guard, far above the 160 or so cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors = num_errors + 1;
      summarize();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      num_errors++;
    end
  endtask : chk
  task acc(input logic [3:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'h3, w, a, 4'h1, 24'h0, d};
    do @(posedge clk); while (ack !== 1'h1 && ++n < 50);
    if (n == 50) num_errors++;
    q = dat_o;
    {cyc, stb} <= 2'h0;
  endtask : acc
  task rd(input logic [3:0] a, input logic [31:0] e);
    acc(a, 1'h0, 8'h00);
    chk(q, e);
  endtask : rd
  task pulse(input int i);
    @(posedge clk);
    cause[i] <= 1'h1;
    repeat (4) @(posedge clk);
    cause[i] <= 1'h0;
    repeat (4) @(posedge clk);
  endtask : pulse
  initial begin
    {cyc, stb, we, brk, adr, sel, dat, cause, rst_n} = '0;
    num_errors = 0;
    check_count = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    rd(4'h0, 32'h80);
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    acc(4'h1, 1'h1, 8'hFF);
    rd(4'h1, 32'h0);
    acc(4'hC, 1'h1, 8'h7E);
    rd(4'hC, 32'h7E);
    for (int i = 0; i < 6; i++) pulse(i);
    chk({31'h0, irq}, 32'h1);
    rd(4'h8, 32'h7E);
    acc(4'h8, 1'h1, 8'h7E);
    acc(4'hC, 1'h1, 8'h00);
    pulse(0);
    chk({31'h0, irq}, 32'h0);
    rd(4'h0, 32'h7E);
    pulse(5);
    rst_n <= 1'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    rd(4'h0, 32'h80);
    brk <= 1'h1;
    pulse(4);
    chk({31'h0, allow}, 32'h0);
    rd(4'h0, 32'h20);
    rd(4'h0, 32'h20);
    acc(4'h8, 1'h1, 8'h20);
    rd(4'h8, 32'h20);
    acc(4'h4, 1'h1, 8'h80);
    rd(4'h4, 32'h80);
    repeat (4) @(posedge clk);
    chk({31'h0, allow}, 32'h1);
    rd(4'h0, 32'h20);
    acc(4'h8, 1'h1, 8'h20);
    rd(4'h8, 32'h0);
    brk <= 1'h0;
    rd(4'h0, 32'h0);
    summarize();
  end
endmodule : rsf_reset_flags_bench
`default_nettype wire
